// [design/csr_consts.svh]
// constants for the clock source and reset sequencer
// How it works
// - radio gets selected fast clock; peripherals get half-rate enable copy.
// - cpu clock is fast clock divided by 1, 2, 4, 8, 16 or 32.
// - every reset or sleep exit starts the fast clock on the rc oscillator.
// - after wake, auto switch to crystal, wait for software, or stay on rc.
// - never switch to crystal before crystal amplitude ready is seen.
// - slow clock source defaults to internal rc on any chip reset.
// - a chosen slow source persists until the next chip reset.
// - slow mux offers rc, external clock on pin a, crystal on pins a/b.
// - wake timers use only the slow clock; all else uses fast clock.
// - slow rc is counted in peripheral clock ticks for calibration.
// - on power-up or pin release enable both fast oscillators, wait 13 us.
// - regulators turn on only while supply is above default threshold.
// - wait 15 us regulator settle, then 150 us memory init and load.
// - apply loaded threshold, wait 2.5 us, recheck, then release reset.
// - after release the boot search starts, flash first then serial memory.
// - five reset sources: brownout, pin, software, watchdog, supply detect.
// - any system reset returns to start state and holds cpu at vector.
// - fast rc trim value survives speed changes and oscillator disable.
// - supply threshold has eight settings, loaded at power-up, default code 1.
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CSR_CLK_MHZ 100
`define CSR_T_RC_START_NS 13000
`define CSR_T_REG_NS 15000
`define CSR_T_MEM_NS 150000
`define CSR_T_PAUSE_NS 2500
`define CSR_CYC(ns) ((((ns) * `CSR_CLK_MHZ) + 999) / 1000)
`define CSR_CNT_W 16
// -----------------------------------------------------------------
// field values
// -----------------------------------------------------------------
`define CSR_THR_DEFAULT 3'h1
`define CSR_DIV_MAX 3'h5
`define CSR_CAL_W 16
`endif

// [design/csr_pkg.sv]
// types for the clock source and reset sequencer
package csr_pkg;
  typedef enum logic [1:0] {CSR_POL_AUTO, CSR_POL_SW, CSR_POL_STAY} csr_policy_t;
  typedef enum logic [1:0] {CSR_SLOW_RC, CSR_SLOW_EXT, CSR_SLOW_XTAL} csr_slow_t;
  typedef enum {CSR_S_RC_WAIT, CSR_S_SUPPLY, CSR_S_REG, CSR_S_MEM, CSR_S_PAUSE,
    CSR_S_CHECK, CSR_S_RUN} csr_seq_t;
endpackage : csr_pkg

// [design/csr_clock_reset_seq.sv]
// clock source selection, dividers and reset release sequencer
`timescale 1ns/100ps
`include "csr_consts.svh"
module csr_clock_reset_seq #(
  parameter int unsigned RC_START_CYC = `CSR_CYC(`CSR_T_RC_START_NS),
  parameter int unsigned REG_CYC = `CSR_CYC(`CSR_T_REG_NS),
  parameter int unsigned MEM_CYC = `CSR_CYC(`CSR_T_MEM_NS),
  parameter int unsigned PAUSE_CYC = `CSR_CYC(`CSR_T_PAUSE_NS)
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // reset sources, asynchronous to this clock, through a synchroniser; sleep exit used without one
  input wire logic i_brownout_reset,
  input wire logic i_reset_pin_n,
  input wire logic i_soft_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_supply_detect_reset,
  input wire logic i_sleep_exit,
  // supply monitor and oscillators
  input wire logic i_supply_ok,
  input wire logic i_xtal_amp_ready,
  input wire logic i_slow_rc_clk,
  input wire logic [2:0] i_flash_threshold,
  input wire logic i_flash_load_done,
  // software controls
  input wire logic [1:0] i_policy,
  input wire logic i_sw_switch_req,
  input wire logic [2:0] i_cpu_div_sel,
  input wire logic [1:0] i_slow_src_sel,
  input wire logic i_slow_src_write,
  input wire logic [7:0] i_rc_trim_in,
  input wire logic i_rc_trim_write,
  input wire logic i_cal_start,
  input wire logic [7:0] i_cal_periods,
  // oscillator and regulator controls
  output logic o_rc_osc_en,
  output logic o_xtal_osc_en,
  output logic o_regulator_en,
  output logic [2:0] o_supply_threshold,
  output logic o_fast_src_xtal,
  output logic [7:0] o_rc_trim,
  // clock enables for the consumers
  output logic o_radio_clk_en,
  output logic o_periph_clk_en,
  output logic o_cpu_clk_en,
  // slow clock mux and pin use
  output logic [1:0] o_slow_src,
  output logic o_shared_io_pin_a_clk_use,
  output logic o_shared_io_pin_b_clk_use,
  // reset and status
  output logic o_core_reset,
  output logic o_boot_start,
  output logic o_xtal_ready,
  output logic o_cal_busy,
  output logic [`CSR_CAL_W-1:0] o_cal_count
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rst_m;
    logic [1:0] rst_s;
    logic [1:0] xr_m;
    logic [1:0] xr_s;
    logic [1:0] sup_m;
    logic [1:0] sup_s;
    logic [2:0] slo;
    csr_pkg::csr_seq_t seq;
    logic [`CSR_CNT_W-1:0] cnt;
    logic xtal;
    logic sw_pend;
    logic [2:0] thr;
    logic [1:0] slow;
    logic [7:0] trim;
    logic [4:0] div;
    logic [2:0] div_sel;
    logic half;
    logic boot;
    logic cal_busy;
    logic [7:0] cal_left;
    logic [`CSR_CAL_W-1:0] cal_cnt;
  } csr_state_t;

  csr_state_t st;
  csr_state_t next_st;
  logic any_rst;
  logic slow_rise;

  // reset requests from any of the five sources force a restart
  assign any_rst = st.rst_s[1];

  // load a wait counter in cycles
  function automatic logic [`CSR_CNT_W-1:0] csr_ld(input int unsigned cyc);
    csr_ld = `CSR_CNT_W'(cyc - 1);
  endfunction : csr_ld

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // four-stage synchronisers (m then s pair), last stage only is read
    next_st.rst_m = {st.rst_m[0], i_brownout_reset | ~i_reset_pin_n | i_soft_reset |
      i_watchdog_reset | i_supply_detect_reset};
    next_st.rst_s = {st.rst_s[0], st.rst_m[1]};
    next_st.xr_m = {st.xr_m[0], i_xtal_amp_ready};
    next_st.xr_s = {st.xr_s[0], st.xr_m[1]};
    next_st.sup_m = {st.sup_m[0], i_supply_ok};
    next_st.sup_s = {st.sup_s[0], st.sup_m[1]};
    next_st.slo = {st.slo[1:0], i_slow_rc_clk};
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - `CSR_CNT_W'(1);
    end
    next_st.boot = 1'b0;
    // timed release sequence
    case (st.seq)
      csr_pkg::CSR_S_RC_WAIT: begin
        if (st.cnt == '0) begin
          next_st.seq = csr_pkg::CSR_S_SUPPLY;
        end
      end
      csr_pkg::CSR_S_SUPPLY: begin
        if (st.sup_s[1]) begin
          next_st.seq = csr_pkg::CSR_S_REG;
          next_st.cnt = csr_ld(REG_CYC);
        end
      end
      csr_pkg::CSR_S_REG: begin
        if (!st.sup_s[1]) begin
          next_st.seq = csr_pkg::CSR_S_SUPPLY;
        end else if (st.cnt == '0) begin
          next_st.seq = csr_pkg::CSR_S_MEM;
          next_st.cnt = csr_ld(MEM_CYC);
        end
      end
      csr_pkg::CSR_S_MEM: begin
        if (st.cnt == '0 && i_flash_load_done) begin
          next_st.thr = i_flash_threshold;
          next_st.seq = csr_pkg::CSR_S_PAUSE;
          next_st.cnt = csr_ld(PAUSE_CYC);
        end
      end
      csr_pkg::CSR_S_PAUSE: begin
        if (st.cnt == '0) begin
          next_st.seq = csr_pkg::CSR_S_CHECK;
        end
      end
      csr_pkg::CSR_S_CHECK: begin
        if (st.sup_s[1]) begin
          next_st.seq = csr_pkg::CSR_S_RUN;
          next_st.boot = 1'b1;
        end
      end
      csr_pkg::CSR_S_RUN: begin
        next_st.seq = csr_pkg::CSR_S_RUN;
      end
      default: begin
        next_st.seq = csr_pkg::CSR_S_RC_WAIT;
      end
    endcase
    // fast source: switch only with crystal ready, per policy
    if (i_sw_switch_req) begin
      next_st.sw_pend = 1'b1;
    end
    if (!st.xtal && st.xr_s[1] && st.seq == csr_pkg::CSR_S_RUN) begin
      if (i_policy == 2'(csr_pkg::CSR_POL_AUTO) ||
          (i_policy == 2'(csr_pkg::CSR_POL_SW) && (st.sw_pend || i_sw_switch_req))) begin
        next_st.xtal = 1'b1;
        next_st.sw_pend = 1'b0;
      end
    end
    // a sleep exit returns to the rc source
    if (i_sleep_exit) begin
      next_st.xtal = 1'b0;
      next_st.sw_pend = 1'b0;
    end
    // slow source can be changed once away from rc, then sticks
    if (i_slow_src_write && st.slow == 2'(csr_pkg::CSR_SLOW_RC) &&
        i_slow_src_sel != 2'h3) begin
      next_st.slow = i_slow_src_sel;
    end
    // trim kept in state that no speed or source change touches
    if (i_rc_trim_write) begin
      next_st.trim = i_rc_trim_in;
    end
    // dividers: a single free counter; enables change only at wrap
    next_st.div = st.div + 5'h01;
    next_st.half = ~st.half;
    if (st.div == 5'h1f) begin
      next_st.div_sel = (i_cpu_div_sel > `CSR_DIV_MAX) ? `CSR_DIV_MAX : i_cpu_div_sel;
    end
    // slow rc measured in peripheral ticks
    if (i_cal_start && !st.cal_busy) begin
      next_st.cal_busy = 1'b1;
      next_st.cal_left = i_cal_periods;
      next_st.cal_cnt = '0;
    end else if (st.cal_busy) begin
      if (st.half) begin
        next_st.cal_cnt = st.cal_cnt + `CSR_CAL_W'(1);
      end
      if (slow_rise) begin
        if (st.cal_left <= 8'h01) begin
          next_st.cal_busy = 1'b0;
        end
        next_st.cal_left = st.cal_left - 8'h01;
      end
    end
    // any reset source restarts the sequence on rc
    if (any_rst) begin
      next_st.seq = csr_pkg::CSR_S_RC_WAIT;
      next_st.cnt = csr_ld(RC_START_CYC);
      next_st.xtal = 1'b0;
      next_st.sw_pend = 1'b0;
      next_st.slow = 2'(csr_pkg::CSR_SLOW_RC);
      next_st.thr = `CSR_THR_DEFAULT;
      next_st.cal_busy = 1'b0;
      // a request in the release cycle must not leave a stray boot pulse
      next_st.boot = 1'b0;
    end
  end

  // synchronised slow rc rising edge, second and third stage only
  assign slow_rise = st.slo[1] & ~st.slo[2];

  // -----------------------------------------------------------------
  // register
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.seq <= csr_pkg::CSR_S_RC_WAIT;
      st.cnt <= `CSR_CNT_W'(RC_START_CYC - 1);
      st.thr <= `CSR_THR_DEFAULT;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign o_rc_osc_en = 1'b1;
  assign o_xtal_osc_en = 1'b1;
  assign o_regulator_en = (st.seq != csr_pkg::CSR_S_RC_WAIT) &&
    (st.seq != csr_pkg::CSR_S_SUPPLY);
  assign o_supply_threshold = st.thr;
  assign o_fast_src_xtal = st.xtal;
  assign o_xtal_ready = st.xr_s[1];
  assign o_rc_trim = st.trim;
  // enables are one fast cycle wide, so no shortened phase
  assign o_radio_clk_en = 1'b1;
  assign o_periph_clk_en = st.half;
  assign o_cpu_clk_en = ((st.div & ((5'h01 << st.div_sel) - 5'h01)) == 5'h00);
  // wake timers use this slow selection only
  assign o_slow_src = st.slow;
  assign o_shared_io_pin_a_clk_use = st.slow != 2'(csr_pkg::CSR_SLOW_RC);
  assign o_shared_io_pin_b_clk_use = st.slow == 2'(csr_pkg::CSR_SLOW_XTAL);
  assign o_core_reset = st.seq != csr_pkg::CSR_S_RUN;
  assign o_boot_start = st.boot;
  assign o_cal_busy = st.cal_busy;
  assign o_cal_count = st.cal_cnt;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  xtal_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(st.xtal) |-> $past(st.xr_s[1]))
    else $error("crystal chosen before ready");
  rc_after_rst_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    any_rst |=> !st.xtal)
    else $error("fast clock not on rc after reset");
  reg_supply_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st.seq == csr_pkg::CSR_S_SUPPLY && !st.sup_s[1] && !any_rst) |=> !o_regulator_en)
    else $error("regulators on without supply");
  release_chk_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $fell(o_core_reset) |-> $past(st.sup_s[1]) && $past(st.seq == csr_pkg::CSR_S_CHECK))
    else $error("reset released without supply check");
  slow_default_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    any_rst |=> o_slow_src == 2'(csr_pkg::CSR_SLOW_RC))
    else $error("slow source not rc after reset");
  slow_sticky_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st.slow != 2'(csr_pkg::CSR_SLOW_RC) && !any_rst) |=> $stable(st.slow))
    else $error("slow source changed without reset");
  periph_half_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_periph_clk_en |=> !o_periph_clk_en ##1 o_periph_clk_en)
    else $error("peripheral enable not half rate");
  boot_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_boot_start |-> $past(o_core_reset) && !o_core_reset)
    else $error("boot start not at release");
  trim_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_rc_trim_write |=> $stable(o_rc_trim))
    else $error("trim lost");
  reset_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    any_rst |=> o_core_reset && !o_boot_start)
    else $error("core released during reset request");
  regulator_rise_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_regulator_en) |-> $past(st.sup_s[1]))
    else $error("regulators started without supply");
  stay_rc_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_policy == 2'(csr_pkg::CSR_POL_STAY) && !st.xtal) |=> !st.xtal)
    else $error("left rc under stay policy");
endmodule : csr_clock_reset_seq

// [dv/csr_osc_model.sv]
// behavioural oscillators, regulators, flash loader and supply monitor
`timescale 1ns/100ps
module csr_osc_model #(
  parameter int unsigned XTAL_CYC = 6,
  parameter int unsigned LOAD_CYC = 3
) (
  // clock
  input wire logic i_clk_sys,
  // bench controls
  input wire logic i_supply_good,
  input wire logic i_xtal_go,
  input wire logic [2:0] i_thr_code,
  // from the sequencer
  input wire logic i_xtal_osc_en,
  input wire logic i_regulator_en,
  // to the sequencer
  output logic o_supply_ok,
  output logic o_xtal_amp_ready,
  output logic o_slow_rc_clk,
  output logic o_flash_load_done,
  output logic [2:0] o_flash_threshold
);
  int xc = 0;
  int lc = 0;
  int sc = 0;
  logic slow_wave = 1'b0;
  // -------------------------------------------------
  // crystal start, flash load and slow rc wave
  // -------------------------------------------------
  always @(posedge i_clk_sys) begin
    xc <= (i_xtal_go && i_xtal_osc_en) ? ((xc < XTAL_CYC) ? xc + 1 : xc) : 0;
    lc <= i_regulator_en ? ((lc < LOAD_CYC) ? lc + 1 : lc) : 0;
    sc <= (sc == 9) ? 0 : sc + 1;
    if (sc == 9) begin
      slow_wave <= ~slow_wave;
    end
  end
  // slow rc runs from time zero, so software may rely on it
  assign o_slow_rc_clk = slow_wave;
  // amplitude flag only once the crystal has had time to build up
  assign o_xtal_amp_ready = (xc >= XTAL_CYC);
  assign o_flash_load_done = (lc >= LOAD_CYC);
  // threshold bus is junk until the load finishes, so a early sample shows
  assign o_flash_threshold = o_flash_load_done ? i_thr_code : ~i_thr_code;
  // supply held low by the bench until limits are met
  assign o_supply_ok = i_supply_good;
endmodule : csr_osc_model

// [dv/csr_clock_reset_seq_test.sv]
// self-checking bench for the clock source and reset sequencer
`timescale 1ns/100ps
`include "csr_consts.svh"
module csr_clock_reset_seq_test;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_brownout_reset = 1'b0, i_reset_pin_n = 1'b1;
  logic i_soft_reset = 1'b0, i_watchdog_reset = 1'b0, i_supply_detect_reset = 1'b0;
  logic i_sleep_exit = 1'b0, i_sw_switch_req = 1'b0, i_slow_src_write = 1'b0;
  logic i_rc_trim_write = 1'b0, i_cal_start = 1'b0, supply_good = 1'b0, xtal_go = 1'b0;
  logic [1:0] i_policy = 2'h0, i_slow_src_sel = 2'h0;
  logic [2:0] i_cpu_div_sel = 3'h0, thr = 3'h1;
  logic [7:0] i_rc_trim_in = 8'h00, i_cal_periods = 8'h04, trim;
  logic i_supply_ok, i_xtal_amp_ready, i_slow_rc_clk, i_flash_load_done;
  logic [2:0] i_flash_threshold, o_supply_threshold;
  logic o_rc_osc_en, o_xtal_osc_en, o_regulator_en, o_fast_src_xtal, o_radio_clk_en;
  logic o_periph_clk_en, o_cpu_clk_en, o_shared_io_pin_a_clk_use, o_shared_io_pin_b_clk_use;
  logic o_core_reset, o_boot_start, o_xtal_ready, o_cal_busy;
  logic [1:0] o_slow_src;
  logic [7:0] o_rc_trim;
  logic [`CSR_CAL_W-1:0] o_cal_count;
  logic [31:0] seed = 32'he3fc;
  int n_errors = 0, comparisons = 0, np, nc, nr;
  always #5 i_clk_sys = ~i_clk_sys;
  csr_osc_model osc (.i_clk_sys, .i_supply_good(supply_good), .i_xtal_go(xtal_go),
    .i_thr_code(thr), .i_xtal_osc_en(o_xtal_osc_en), .i_regulator_en(o_regulator_en),
    .o_supply_ok(i_supply_ok), .o_xtal_amp_ready(i_xtal_amp_ready),
    .o_slow_rc_clk(i_slow_rc_clk), .o_flash_load_done(i_flash_load_done),
    .o_flash_threshold(i_flash_threshold));
  csr_clock_reset_seq #(.RC_START_CYC(4), .REG_CYC(4), .MEM_CYC(4), .PAUSE_CYC(4)) uut (
    .i_clk_sys, .i_rst, .i_brownout_reset, .i_reset_pin_n, .i_soft_reset, .i_watchdog_reset,
    .i_supply_detect_reset, .i_sleep_exit, .i_supply_ok, .i_xtal_amp_ready, .i_slow_rc_clk,
    .i_flash_threshold, .i_flash_load_done, .i_policy, .i_sw_switch_req, .i_cpu_div_sel,
    .i_slow_src_sel, .i_slow_src_write, .i_rc_trim_in, .i_rc_trim_write, .i_cal_start,
    .i_cal_periods, .o_rc_osc_en, .o_xtal_osc_en, .o_regulator_en, .o_supply_threshold,
    .o_fast_src_xtal, .o_rc_trim, .o_radio_clk_en, .o_periph_clk_en, .o_cpu_clk_en,
    .o_slow_src, .o_shared_io_pin_a_clk_use, .o_shared_io_pin_b_clk_use, .o_core_reset,
    .o_boot_start, .o_xtal_ready, .o_cal_busy, .o_cal_count);
  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // single-cycle strobe, sampled at exactly one rising edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // bounded wait for the release pulse
  task automatic wait_boot();
    int k;
    for (k = 0; k < 500 && o_boot_start !== 1'b1; k++) tick(1);
    check("boot_start seen", 16'h1, {15'h0, k < 500});
    tick(1);
    check("core_reset released", 16'h0, o_core_reset);
  endtask : wait_boot
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // watchdog: whole run is about fourteen hundred cycles
  initial begin : watchdog
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    test_done();
  end
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  initial begin : main
    tick(3);
    check("threshold in reset", 16'h1, o_supply_threshold);
    check("fast src in reset", 16'h0, o_fast_src_xtal);
    check("slow src in reset", 16'h0, o_slow_src);
    check("pins free for flash", 16'h0, {14'h0, o_shared_io_pin_a_clk_use, o_shared_io_pin_b_clk_use});
    i_rst = 1'b0;
    tick(40);
    check("regulator while supply low", 16'h0, o_regulator_en);
    check("core reset while supply low", 16'h1, o_core_reset);
    check("osc enables", 16'h3, {14'h0, o_rc_osc_en, o_xtal_osc_en});
    seed = lfsr(seed);
    thr = seed[2:0];
    supply_good = 1'b1;
    wait_boot();
    check("loaded threshold", {13'h0, thr}, o_supply_threshold);
    check("regulator on", 16'h1, o_regulator_en);
    tick(20);
    check("fast src before ready", 16'h0, o_fast_src_xtal);
    xtal_go = 1'b1;
    tick(14);
    check("auto switch", 16'h1, o_fast_src_xtal);
    check("xtal ready status", 16'h1, o_xtal_ready);
    $display("test sequence and auto switch done");
    // trim survives sleep; software switch and stay policies
    seed = lfsr(seed);
    trim = seed[7:0];
    i_rc_trim_in = trim;
    pulse(i_rc_trim_write);
    i_policy = csr_pkg::CSR_POL_SW;
    xtal_go = 1'b0;
    tick(4);
    pulse(i_sleep_exit);
    tick(2);
    check("fast src after sleep", 16'h0, o_fast_src_xtal);
    check("trim kept", {8'h0, trim}, o_rc_trim);
    xtal_go = 1'b1;
    tick(14);
    check("no switch without request", 16'h0, o_fast_src_xtal);
    pulse(i_sw_switch_req);
    tick(4);
    check("software switch", 16'h1, o_fast_src_xtal);
    i_policy = csr_pkg::CSR_POL_STAY;
    pulse(i_sleep_exit);
    tick(14);
    check("stay on rc", 16'h0, o_fast_src_xtal);
    $display("test policies done");
    // radio only counted once the fast clock is back on the crystal
    i_policy = csr_pkg::CSR_POL_AUTO;
    // every divider setting, clamped codes too, with half-rate and radio enables
    for (int s = 0; s < 8; s++) begin
      i_cpu_div_sel = s[2:0];
      tick(64);
      np = 0;
      nc = 0;
      nr = 0;
      repeat (64) begin
        np += o_periph_clk_en;
        nc += o_cpu_clk_en;
        nr += o_radio_clk_en;
        tick(1);
      end
      check("cpu enables", 16'(64 >> ((s > 5) ? 5 : s)), 16'(nc));
      check("periph enables", 16'd32, 16'(np));
      check("radio enables", 16'd64, 16'(nr));
      check("radio on crystal", 16'h1, o_fast_src_xtal);
    end
    $display("test dividers done");
    // slow source: sticky external choice, crystal after a chip reset
    i_slow_src_sel = 2'h1;
    pulse(i_slow_src_write);
    tick(2);
    check("slow src ext", 16'h1, o_slow_src);
    check("pin a use", 16'h1, o_shared_io_pin_a_clk_use);
    i_slow_src_sel = 2'h2;
    pulse(i_slow_src_write);
    tick(2);
    check("slow src sticky", 16'h1, o_slow_src);
    i_rst = 1'b1;
    tick(2);
    check("slow src cleared", 16'h0, o_slow_src);
    i_rst = 1'b0;
    wait_boot();
    i_slow_src_sel = 2'h3;
    pulse(i_slow_src_write);
    tick(2);
    check("slow src code 3 ignored", 16'h0, o_slow_src);
    i_slow_src_sel = 2'h2;
    pulse(i_slow_src_write);
    tick(2);
    check("slow src xtal", 16'h2, o_slow_src);
    check("pin b use", 16'h1, o_shared_io_pin_b_clk_use);
    $display("test slow source done");
    // each of the five reset sources restarts the sequence
    for (int k = 0; k < 5; k++) begin
      {i_brownout_reset, i_soft_reset, i_watchdog_reset, i_supply_detect_reset} = 4'h0;
      i_reset_pin_n = (k != 1);
      case (k)
        0: i_brownout_reset = 1'b1;
        2: i_soft_reset = 1'b1;
        3: i_watchdog_reset = 1'b1;
        4: i_supply_detect_reset = 1'b1;
        default: ;
      endcase
      tick(6);
      check("core reset by source", 16'h1, o_core_reset);
      {i_brownout_reset, i_soft_reset, i_watchdog_reset, i_supply_detect_reset} = 4'h0;
      i_reset_pin_n = 1'b1;
      wait_boot();
    end
    $display("test reset sources done");
    // calibration: four slow rc periods of 20 cycles, 10 periph ticks each
    pulse(i_cal_start);
    tick(1);
    check("cal busy", 16'h1, o_cal_busy);
    for (int k = 0; k < 500 && o_cal_busy === 1'b1; k++) tick(1);
    check("cal done", 16'h0, o_cal_busy);
    check("cal count in range", 16'h1, {15'h0, o_cal_count >= 28 && o_cal_count <= 46});
    $display("test calibration done");
    test_done();
  end
endmodule : csr_clock_reset_seq_test
